/* File: rtl/sfl_core.sv */
// Contract
// RQ1: Opcode, address and dummy bits are sampled on rising serial clock edges.
// RQ2: Fast read drives data on falling edges after dummy byte, address increments.
// RQ3: Dual read drives two bits per clock on both pins, address increments.
// RQ4: Dual mode puts even bits on pin 0, odd bits on pin 1, MSB first.
// RQ5: Identification read after zero address returns manufacturer then device byte.
// RQ6: Identification read with address one returns device byte first.
// RQ7: Standard identification returns manufacturer, memory type, capacity on falling edges.
// RQ8: Standard identification is not decoded while a program cycle runs.
// RQ9: Host does not send standard identification during deep power-down.
// RQ10: Raising chip select ends identification output; device returns to standby.
// RQ11: Unique number read takes four dummy bytes then shifts out 64 bits.
// RQ12: Deep power-down entered only if select rises right after opcode.
// RQ13: In deep power-down only the release command is recognised.
// RQ14: Bare release resumes normal operation after the first release time.
// RQ15: Release with three dummies outputs device byte repeatedly until deselect.
// RQ16: Host waits the second release time after release with identification.
// RQ17: Release and identification command ignored while write in progress.
// RQ18: Host sets write enable, then opcode, address and data bytes.
// RQ19: Program bytes beyond page end wrap to the page start.
// RQ20: Only the last 256 bytes kept; unsent page bytes untouched.
// RQ21: Program executes only if select rises on a data byte boundary.
// RQ22: Select rise starts timed cycle, write in progress set, latch cleared.
// RQ23: Program to a protected page is not executed.
// RQ24: Write enable opcode sets the latch, required before programming.
// RQ25: Bits shift MSB first; outputs float while deselected.
`timescale 1ns/100ps
`default_nettype none
`include "sfl_cfg.svh"
module sfl_core import sfl_pkg::*; #(
  parameter int MEM_AW = 19,
  parameter logic [7:0] MFR_ID = 8'h5a,          // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h30,        // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h13,        // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h12,          // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef, // Arbitrary value
  parameter int PROG_CYCLES = `SFL_PROG_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clock_i,
  input wire logic dual_data_pin_0_i,
  output logic dual_data_pin_0_o,
  output logic dual_data_pin_0_oe_n_o,
  output logic dual_data_pin_1_o,
  output logic dual_data_pin_1_oe_n_o,
  input wire logic [2:0] block_protect_bits_i,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic deep_power_down_o
);
  localparam int TDP_CYC = (`SFL_TDP_NS * `SFL_CLK_MHZ / 1000 < 1) ? 1 :
                           `SFL_TDP_NS * `SFL_CLK_MHZ / 1000;
  localparam int RELEASE_WAIT_TIME_CYC = (`SFL_RELEASE_WAIT_TIME_NS * `SFL_CLK_MHZ + 999) / 1000;
  localparam int RELEASE_ID_WAIT_TIME_CYC = (`SFL_RELEASE_ID_WAIT_TIME_NS * `SFL_CLK_MHZ + 999) / 1000;
  localparam int PAGE_AW = MEM_AW - 8;

  logic [2:0] sync_lvl;
  logic [2:0] sync_rise;
  logic [2:0] sync_fall;
  logic cs_n;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic si;

  sfl_pin_sync #(.W(3), .INIT(3'h1)) u_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i({dual_data_pin_0_i, serial_clock_i, chip_select_n_i}),
    .level_o(sync_lvl),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );

  assign cs_n = sync_lvl[0];
  assign cs_rise = sync_rise[0];
  assign sclk_rise = sync_rise[1] & ~cs_n;
  assign sclk_fall = sync_fall[1] & ~cs_n;
  assign si = sync_lvl[2];

  sfl_phase_t phase;
  sfl_power_t pw;
  sfl_prog_t pg;
  logic [7:0] opcode;
  logic [6:0] sr;
  logic [2:0] bit_cnt;
  logic [2:0] cmd_bytes;
  logic [1:0] phase_cnt;
  logic [1:0] dummy_last;
  logic [23:0] addr;
  logic [7:0] byte_in;
  logic byte_done;
  logic [MEM_AW-1:0] out_cnt;
  logic [1:0] jed_idx;
  logic [2:0] out_bit;
  logic [7:0] out_byte;
  logic [7:0] mem [0:(2**MEM_AW)-1];
  logic [7:0] pg_buf [0:255];
  logic [255:0] pg_mask;
  logic pg_has_data;
  logic [PAGE_AW-1:0] pg_page;
  logic [7:0] pg_idx;
  logic [31:0] pg_cnt;
  logic [15:0] pw_cnt;
  logic op_only;
  logic prog_go;
  logic wren_go;
  logic wrdi_go;
  logic dpd_go;
  logic rel_go;
  logic [7:0] next_opcode;

  // Protection covers the top 2^(bp-1) eighths of the array; 4 and up covers all
  function automatic logic sfl_protected(input logic [2:0] bp, input logic [2:0] top3);
    logic [3:0] span;
    span = 4'h1 << bp;
    sfl_protected = (bp != 3'h0) && ({1'b0, top3} >= 4'h8 - {1'b0, span[3:1]}) ||
                    (bp >= 3'h4);
  endfunction

  assign byte_in = {sr, si};
  assign byte_done = sclk_rise && (bit_cnt == 3'h7);
  assign op_only = (cmd_bytes == 3'h1) && (bit_cnt == 3'h0);

  always_comb begin
    next_opcode = byte_in;
    if (pw != SFL_PW_NORM && !(pw == SFL_PW_DOWN && byte_in == `SFL_OP_REL)) begin
      next_opcode = `SFL_OP_NONE; // RQ13
    end else if (pg != SFL_PG_IDLE) begin
      next_opcode = `SFL_OP_NONE; // RQ8 RQ17
    end
  end

  // Select-rise actions; ignored commands carry no opcode
  assign prog_go = cs_rise && opcode == `SFL_OP_PROG && phase == SFL_PGDATA &&
                   bit_cnt == 3'h0 && pg_has_data && write_enable_latch_o && // RQ21 RQ24
                   !sfl_protected(block_protect_bits_i, addr[MEM_AW-1:MEM_AW-3]); // RQ23
  assign wren_go = cs_rise && op_only && opcode == `SFL_OP_WREN; // RQ24
  assign wrdi_go = cs_rise && op_only && opcode == `SFL_OP_WRDI;
  assign dpd_go = cs_rise && op_only && opcode == `SFL_OP_DPD; // RQ12
  assign rel_go = cs_rise && opcode == `SFL_OP_REL && pw == SFL_PW_DOWN;

  // Command shifter
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      phase <= SFL_CMD;
      opcode <= `SFL_OP_NONE;
      sr <= 7'h00;
      bit_cnt <= 3'h0;
      cmd_bytes <= 3'h0;
      phase_cnt <= 2'h0;
      dummy_last <= 2'h0;
      addr <= 24'h000000;
    end else if (cs_n) begin
      phase <= SFL_CMD; // RQ10
      bit_cnt <= 3'h0;
      cmd_bytes <= 3'h0;
    end else if (sclk_rise) begin
      sr <= byte_in[6:0]; // RQ1 RQ25
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (cmd_bytes != 3'h7) begin
          cmd_bytes <= cmd_bytes + 3'h1;
        end
        phase_cnt <= phase_cnt + 2'h1;
        case (phase)
          SFL_CMD: begin
            opcode <= next_opcode;
            phase_cnt <= 2'h0;
            case (next_opcode)
              `SFL_OP_FAST, `SFL_OP_DUAL, `SFL_OP_MFDEV, `SFL_OP_PROG: begin
                phase <= SFL_ADDR;
              end
              `SFL_OP_JEDEC: begin
                phase <= SFL_OUT; // RQ7
              end
              `SFL_OP_UID: begin
                phase <= SFL_DUMMY; // RQ11
                dummy_last <= `SFL_DUMMY_UID;
              end
              `SFL_OP_REL: begin
                phase <= SFL_DUMMY; // RQ15
                dummy_last <= `SFL_DUMMY_REL;
              end
              default: begin
                phase <= SFL_IGNORE;
              end
            endcase
          end
          SFL_ADDR: begin
            addr <= {addr[15:0], byte_in};
            if (phase_cnt == `SFL_ADDR_LAST) begin
              phase_cnt <= 2'h0;
              dummy_last <= `SFL_DUMMY_READ;
              case (opcode)
                `SFL_OP_MFDEV: phase <= SFL_OUT; // RQ5
                `SFL_OP_PROG: phase <= SFL_PGDATA;
                default: phase <= SFL_DUMMY; // RQ1
              endcase
            end
          end
          SFL_DUMMY: begin
            if (phase_cnt == dummy_last) begin
              phase <= SFL_OUT;
            end
          end
          SFL_PGDATA: begin
            addr[7:0] <= addr[7:0] + 8'h01; // RQ19
          end
          default: begin
            phase <= phase;
          end
        endcase
      end
    end
  end

  always_comb begin
    case (opcode)
      `SFL_OP_FAST, `SFL_OP_DUAL: out_byte = mem[addr[MEM_AW-1:0] + out_cnt]; // RQ2 RQ3
      `SFL_OP_JEDEC: out_byte = (jed_idx == 2'h0) ? MFR_ID :
                                (jed_idx == 2'h1) ? MEM_TYPE : CAPACITY; // RQ7
      `SFL_OP_MFDEV: out_byte = (out_cnt[0] ^ (addr == 24'h000001)) ? DEV_ID : MFR_ID; // RQ6
      `SFL_OP_UID: out_byte = UNIQUE_ID[{3'h7 - out_cnt[2:0], 3'h0} +: 8]; // RQ11
      default: out_byte = DEV_ID; // RQ15
    endcase
  end

  // Output shifter; drives on falling edges, floats when deselected
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      out_cnt <= '0;
      jed_idx <= 2'h0;
      out_bit <= 3'h0;
      dual_data_pin_0_o <= 1'b0;
      dual_data_pin_0_oe_n_o <= 1'b1;
      dual_data_pin_1_o <= 1'b0;
      dual_data_pin_1_oe_n_o <= 1'b1;
    end else if (cs_n) begin
      out_cnt <= '0;
      jed_idx <= 2'h0;
      out_bit <= 3'h0;
      dual_data_pin_0_oe_n_o <= 1'b1; // RQ25
      dual_data_pin_1_oe_n_o <= 1'b1; // RQ25
    end else if (sclk_fall && phase == SFL_OUT) begin
      dual_data_pin_1_oe_n_o <= 1'b0;
      dual_data_pin_1_o <= out_byte[3'h7 - out_bit]; // RQ2 RQ4
      if (opcode == `SFL_OP_DUAL) begin
        dual_data_pin_0_oe_n_o <= 1'b0; // RQ3
        dual_data_pin_0_o <= out_byte[3'h6 - out_bit]; // RQ4
        out_bit <= out_bit + 3'h2;
      end else begin
        out_bit <= out_bit + 3'h1;
      end
      if (out_bit == 3'h7 || (opcode == `SFL_OP_DUAL && out_bit == 3'h6)) begin
        out_cnt <= out_cnt + 1'b1; // RQ2 RQ3
        jed_idx <= (jed_idx == 2'h2) ? 2'h0 : jed_idx + 2'h1;
      end
    end
  end

  // Page buffer; later bytes overwrite earlier ones at the same offset
  // A frame that opens while the copy still runs must not wipe the mask
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pg_mask <= '0;
      pg_has_data <= 1'b0;
    end else if (phase == SFL_CMD && byte_done && pg == SFL_PG_IDLE) begin
      pg_mask <= '0;
      pg_has_data <= 1'b0;
    end else if (phase == SFL_PGDATA && byte_done) begin
      pg_mask[addr[7:0]] <= 1'b1; // RQ20
      pg_has_data <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (phase == SFL_PGDATA && byte_done) begin
      pg_buf[addr[7:0]] <= byte_in; // RQ20
    end
  end

  always_ff @(posedge clock_i) begin
    if (pg == SFL_PG_WRITE && pg_mask[pg_idx]) begin
      mem[{pg_page, pg_idx}] <= pg_buf[pg_idx]; // RQ20
    end
  end

  // Self-timed program: copy the page, then wait out the cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pg <= SFL_PG_IDLE;
      pg_idx <= 8'h00;
      pg_page <= '0;
      pg_cnt <= 32'h0;
      write_in_progress_o <= 1'b0;
    end else begin
      case (pg)
        SFL_PG_IDLE: begin
          if (prog_go) begin
            pg <= SFL_PG_WRITE; // RQ22
            pg_idx <= 8'h00;
            pg_page <= addr[MEM_AW-1:8];
            write_in_progress_o <= 1'b1; // RQ22
          end
        end
        SFL_PG_WRITE: begin
          pg_idx <= pg_idx + 8'h01;
          if (pg_idx == 8'hff) begin
            pg <= SFL_PG_WAIT;
            pg_cnt <= 32'(PROG_CYCLES);
          end
        end
        SFL_PG_WAIT: begin
          pg_cnt <= pg_cnt - 32'h1;
          if (pg_cnt <= 32'h1) begin
            pg <= SFL_PG_IDLE;
            write_in_progress_o <= 1'b0; // RQ22
          end
        end
        default: begin
          pg <= SFL_PG_IDLE;
        end
      endcase
    end
  end

  // Latch is cleared as the cycle starts, well before it completes
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (prog_go) begin
      write_enable_latch_o <= 1'b0; // RQ22
    end else if (wren_go) begin
      write_enable_latch_o <= 1'b1; // RQ24
    end else if (wrdi_go) begin
      write_enable_latch_o <= 1'b0;
    end
  end

  // Power state
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pw <= SFL_PW_NORM;
      pw_cnt <= 16'h0;
      deep_power_down_o <= 1'b0;
    end else begin
      case (pw)
        SFL_PW_NORM: begin
          if (dpd_go) begin
            pw <= SFL_PW_ENTER; // RQ12
            pw_cnt <= 16'(TDP_CYC);
          end
        end
        SFL_PW_ENTER: begin
          pw_cnt <= pw_cnt - 16'h1;
          if (pw_cnt <= 16'h1) begin
            pw <= SFL_PW_DOWN; // RQ12
            deep_power_down_o <= 1'b1;
          end
        end
        SFL_PW_DOWN: begin
          if (rel_go) begin
            pw <= SFL_PW_WAKE;
            pw_cnt <= op_only ? 16'(RELEASE_WAIT_TIME_CYC) : 16'(RELEASE_ID_WAIT_TIME_CYC); // RQ14 RQ16
          end
        end
        SFL_PW_WAKE: begin
          pw_cnt <= pw_cnt - 16'h1;
          if (pw_cnt <= 16'h1) begin
            pw <= SFL_PW_NORM; // RQ14
            deep_power_down_o <= 1'b0;
          end
        end
        default: begin
          pw <= SFL_PW_NORM;
        end
      endcase
    end
  end
endmodule // sfl_core
`default_nettype wire

/* File: rtl/sfl_cfg.svh */
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// Opcodes
`define SFL_OP_NONE   8'h00
`define SFL_OP_WREN   8'h06
`define SFL_OP_WRDI   8'h04
`define SFL_OP_FAST   8'h0b
`define SFL_OP_DUAL   8'h3b
`define SFL_OP_MFDEV  8'h90
`define SFL_OP_JEDEC  8'h9f
`define SFL_OP_UID    8'h4b
`define SFL_OP_DPD    8'hb9
`define SFL_OP_REL    8'hab
`define SFL_OP_PROG   8'h02

// Dummy bytes after the opcode or address, and address bytes after the opcode, minus one
`define SFL_DUMMY_READ 2'h0
`define SFL_DUMMY_REL  2'h2
`define SFL_DUMMY_UID  2'h3
`define SFL_ADDR_LAST  2'h2

// Timing
`define SFL_CLK_MHZ    250
`define SFL_TDP_NS     3000
`define SFL_RELEASE_WAIT_TIME_NS   3000
`define SFL_RELEASE_ID_WAIT_TIME_NS   3000
`define SFL_PROG_CYC   100000

`endif

/* File: rtl/sfl_pkg.sv */
`default_nettype none
package sfl_pkg;
  typedef enum logic [2:0] {
    SFL_CMD, SFL_ADDR, SFL_DUMMY, SFL_OUT, SFL_PGDATA, SFL_IGNORE
  } sfl_phase_t;
  typedef enum logic [1:0] {
    SFL_PW_NORM, SFL_PW_ENTER, SFL_PW_DOWN, SFL_PW_WAKE
  } sfl_power_t;
  typedef enum logic [1:0] {
    SFL_PG_IDLE, SFL_PG_WRITE, SFL_PG_WAIT
  } sfl_prog_t;
endpackage
`default_nettype wire

/* File: rtl/sfl_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module sfl_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta;
  logic [W-1:0] stab;
  logic [W-1:0] prev;

  // Only stab reads meta; edges come from the settled stages
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= INIT;
      stab <= INIT;
      prev <= INIT;
    end else begin
      meta <= async_i;
      stab <= meta;
      prev <= stab;
    end
  end

  assign level_o = stab;
  assign rise_o = stab & ~prev;
  assign fall_o = ~stab & prev;
endmodule // sfl_pin_sync
`default_nettype wire

/* File: testbench/sfl_core_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module sfl_core_monitor #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clock_i,
  input wire logic dual_data_pin_0_i,
  input wire logic dual_data_pin_0_o,
  input wire logic dual_data_pin_0_oe_n_o,
  input wire logic dual_data_pin_1_o,
  input wire logic dual_data_pin_1_oe_n_o,
  input wire logic [2:0] block_protect_bits_i,
  input wire logic write_in_progress_o,
  input wire logic write_enable_latch_o,
  input wire logic deep_power_down_o
);
  int busy_cnt;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Length of the running self-timed cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) busy_cnt <= 0;
    else if (write_in_progress_o) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  chk_idle_float: assert property (chip_select_n_i [*8] |->
    dual_data_pin_0_oe_n_o && dual_data_pin_1_oe_n_o) else $error("pin driven while idle");
  chk_pin0_pair: assert property (!dual_data_pin_0_oe_n_o |-> !dual_data_pin_1_oe_n_o)
    else $error("pin 0 driven alone");
  chk_launch_wel: assert property ($rose(write_in_progress_o) |->
    !write_enable_latch_o && $past(write_enable_latch_o)) else $error("latch at launch");
  chk_launch_sel: assert property ($rose(write_in_progress_o) |->
    $past(chip_select_n_i, 2)) else $error("cycle began while selected");
  chk_cycle_len: assert property ($fell(write_in_progress_o) |->
    busy_cnt >= PROG_CYCLES) else $error("cycle too short");
  chk_busy_quiet: assert property (write_in_progress_o |-> dual_data_pin_1_oe_n_o)
    else $error("output while busy");
  chk_out_on_fall: assert property (!dual_data_pin_1_oe_n_o &&
    $changed(dual_data_pin_1_o) |-> !$past(serial_clock_i, 2)) else $error("bit not on fall");
  chk_pd_enter: assert property ($rose(deep_power_down_o) |->
    chip_select_n_i && !write_in_progress_o ##1 dual_data_pin_1_oe_n_o [*8])
    else $error("bad power-down entry");
  cover property ($rose(write_in_progress_o));
  cover property ($fell(deep_power_down_o));
  cover property (!dual_data_pin_0_oe_n_o);
endmodule // sfl_core_monitor
bind sfl_core sfl_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.clock_i, .reset_i,
  .chip_select_n_i, .serial_clock_i, .dual_data_pin_0_i, .dual_data_pin_0_o,
  .dual_data_pin_0_oe_n_o, .dual_data_pin_1_o, .dual_data_pin_1_oe_n_o,
  .block_protect_bits_i, .write_in_progress_o, .write_enable_latch_o, .deep_power_down_o);
`default_nettype wire

/* File: testbench/sfl_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sfl_host (
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic mosi_en_o,
  input wire logic io0_i,
  input wire logic io1_i
);
  // Half of the 125 ns link clock; it rests low outside frames
  localparam realtime HALF = 62.5;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    mosi_en_o = 1'b0;
  end
  task automatic sel();
    cs_n_o = 1'b0;
    #(HALF);
  endtask
  // Select stays high for the whole gap, which covers the release waits
  task automatic desel(input int gap);
    #(HALF);
    cs_n_o = 1'b1;
    mosi_en_o = 1'b0;
    #(gap);
  endtask
  // A dual transfer clocks only four bits and leaves pin 0 to the device
  task automatic xfer(input logic [7:0] tx, input bit dual, output logic [7:0] rx);
    mosi_en_o = !dual;
    for (int i = 7; i >= 0; i -= dual ? 2 : 1) begin
      mosi_o = tx[i];
      #(HALF);
      sclk_o = 1'b1;
      rx[i] = io1_i;
      if (dual) rx[i-1] = io0_i;
      #(HALF);
      sclk_o = 1'b0;
    end
  endtask
endmodule // sfl_host
`default_nettype wire

/* File: testbench/sfl_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sfl_core_tb;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] MTYP = 8'h30; // Arbitrary value
  localparam logic [7:0] CAP = 8'h13; // Arbitrary value
  localparam logic [7:0] DEV = 8'h12; // Arbitrary value
  localparam logic [63:0] UID = 64'h0123456789abcdef; // Arbitrary value
  logic clock_i, reset_i, cs_n, sclk, mosi, mosi_en, d0, oe0_n, d1, oe1_n, write_in_progress, write_enable_latch, deep_power_down, drove;
  logic [2:0] bp;
  wire logic io0;
  wire logic io1;
  int n_errors, compares, cyc;
  logic [7:0] got[$];
  // A released pin 1 shows the inverse of its last value, pin 0 shows mosi while the host drives it, else its inverse, never a stale copy
  assign io0 = !oe0_n ? d0 : (mosi_en ? mosi : ~mosi);
  assign io1 = !oe1_n ? d1 : ~d1;
  sfl_core #(.MFR_ID(MFR), .MEM_TYPE(MTYP), .CAPACITY(CAP), .DEV_ID(DEV), .UNIQUE_ID(UID),
    .PROG_CYCLES(600)) dut (.clock_i, .reset_i, .chip_select_n_i(cs_n), .serial_clock_i(sclk),
    .dual_data_pin_0_i(io0), .dual_data_pin_0_o(d0), .dual_data_pin_0_oe_n_o(oe0_n),
    .dual_data_pin_1_o(d1), .dual_data_pin_1_oe_n_o(oe1_n), .block_protect_bits_i(bp),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .deep_power_down_o(deep_power_down));
  sfl_host host (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .mosi_en_o(mosi_en),
    .io0_i(io0), .io1_i(io1));
  always @(negedge oe1_n) drove = 1'b1;
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic fr(input logic [7:0] tx[$], input int nrx, input bit dual, input int gap);
    logic [7:0] rx;
    got = {};
    host.sel();
    foreach (tx[i]) host.xfer(tx[i], 1'b0, rx);
    repeat (nrx) begin
      host.xfer(8'h00, dual, rx);
      got.push_back(rx);
    end
    host.desel(gap);
  endtask
  task automatic mt(input logic [7:0] e[$]);
    chk(16'(got.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h00, got[i]}, {8'h00, e[i]});
  endtask
  task automatic st(input logic [2:0] e);
    chk({13'h0, write_in_progress, write_enable_latch, deep_power_down}, {13'h0, e});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress === 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    st(3'b000);
  endtask
  task automatic t_ids();
    fr({8'h9f}, 1, 1'b0, 100);
    mt({MFR});
    fr({8'h9f}, 3, 1'b0, 100);
    mt({MFR, MTYP, CAP});
    fr({8'h90, 8'h00, 8'h00, 8'h00}, 2, 1'b0, 100);
    mt({MFR, DEV});
    fr({8'h90, 8'h00, 8'h00, 8'h01}, 2, 1'b0, 100);
    mt({DEV, MFR});
    fr({8'hab, 8'h00, 8'h00, 8'h00}, 2, 1'b0, 100);
    mt({DEV, DEV});
    fr({8'h4b, 8'h00, 8'h00, 8'h00, 8'h00}, 8, 1'b0, 100);
    for (int i = 0; i < 8; i++) chk({8'h00, got[i]}, {8'h00, UID[63-8*i -: 8]});
    $display("t_ids done");
  endtask
  task automatic t_prog();
    logic [7:0] q[$];
    fr({8'h06}, 0, 1'b0, 100);
    st(3'b010);
    fr({8'h02, 8'h00, 8'h00, 8'hfe, 8'ha1, 8'hb2, 8'hc3}, 0, 1'b0, 40);
    st(3'b100);
    wait_idle();
    fr({8'h0b, 8'h00, 8'h00, 8'hfe, 8'h00}, 2, 1'b0, 100);
    mt({8'ha1, 8'hb2});
    fr({8'h0b, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1'b0, 100);
    mt({8'hc3});
    fr({8'h3b, 8'h00, 8'h00, 8'hfe, 8'h00}, 2, 1'b1, 100);
    mt({8'ha1, 8'hb2});
    q = {8'h02, 8'h00, 8'h01, 8'h00};
    for (int k = 0; k < 258; k++) q.push_back(8'(k) ^ {8{k[8]}});
    fr({8'h06}, 0, 1'b0, 100);
    fr(q, 0, 1'b0, 100);
    wait_idle();
    fr({8'h0b, 8'h00, 8'h01, 8'h00, 8'h00}, 3, 1'b0, 100);
    mt({8'hff, 8'hfe, 8'h02});
    $display("t_prog done");
  endtask
  task automatic t_refuse();
    fr({8'h02, 8'h00, 8'h02, 8'h00, 8'h55}, 0, 1'b0, 100);
    st(3'b000);
    fr({8'h06}, 0, 1'b0, 100);
    fr({8'h02, 8'h00, 8'h02, 8'h00, 8'h55}, 1, 1'b1, 100);
    st(3'b010);
    @(posedge clock_i);
    #1 bp = 3'h4;
    fr({8'h02, 8'h00, 8'h02, 8'h00, 8'h55}, 0, 1'b0, 100);
    st(3'b010);
    @(posedge clock_i);
    #1 bp = 3'h0;
    fr({8'h02, 8'h00, 8'h02, 8'h00, 8'h66}, 0, 1'b0, 40);
    drove = 1'b0;
    fr({8'h9f}, 1, 1'b0, 40);
    chk({14'h0, drove, write_in_progress}, 16'h0001);
    wait_idle();
    fr({8'h0b, 8'h00, 8'h02, 8'h00, 8'h00}, 1, 1'b0, 100);
    mt({8'h66});
    $display("t_refuse done");
  endtask
  task automatic t_pd();
    fr({8'hb9}, 1, 1'b1, 3200);
    st(3'b000);
    fr({8'hb9}, 0, 1'b0, 3200);
    st(3'b001);
    drove = 1'b0;
    fr({8'h90, 8'h00, 8'h00, 8'h00}, 1, 1'b0, 100);
    chk({14'h0, drove, deep_power_down}, 16'h0001);
    fr({8'hab, 8'h00, 8'h00, 8'h00}, 1, 1'b0, 3200);
    mt({DEV});
    st(3'b000);
    fr({8'hb9}, 0, 1'b0, 3200);
    st(3'b001);
    fr({8'hab}, 0, 1'b0, 3200);
    st(3'b000);
    fr({8'h9f}, 1, 1'b0, 100);
    mt({MFR});
    $display("t_pd done");
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // The run needs roughly 100k cycles; the ceiling leaves a margin
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 125000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    reset_i = 1'b1;
    bp = 3'h0;
    drove = 1'b0;
    repeat (8) @(posedge clock_i);
    #1 reset_i = 1'b0;
    repeat (8) @(posedge clock_i);
    t_ids();
    t_prog();
    t_refuse();
    t_pd();
    results();
  end
endmodule // sfl_core_tb
`default_nettype wire
